// ==== gpm_pkg.sv ====
// Package for the gigabit management register bank: map, fields, resets.
package gpm_pkg;
    // Register indices on the management port.
    localparam logic [4:0] GPM_IDX_GIG_CTRL = 5'h09;
    localparam logic [4:0] GPM_IDX_GIG_STAT = 5'h0A;
    localparam logic [4:0] GPM_IDX_EXT_CTRL = 5'h0D;
    localparam logic [4:0] GPM_IDX_EXT_WIN = 5'h0E;
    localparam logic [4:0] GPM_IDX_ABILITY = 5'h0F;
    localparam logic [4:0] GPM_IDX_FAST_STAT = 5'h10;
    localparam logic [4:0] GPM_IDX_IRQ_STAT = 5'h1C;
    localparam logic [4:0] GPM_IDX_IRQ_MASK = 5'h1D;
    localparam logic [4:0] GPM_IDX_PAGE = 5'h1F;
    // Highest page that holds the gigabit and window registers.
    localparam logic [1:0] GPM_PAGE_MAX = 2'h2;
    localparam logic [1:0] GPM_PAGE_ZERO = 2'h0;
    // Reset values and the idle count ceiling.
    localparam logic [2:0] GPM_TEST_RST = 3'h0;
    localparam logic GPM_ADV_FD_RST = 1'b1;
    localparam logic GPM_ADV_HD_RST = 1'b1;
    localparam logic [15:0] GPM_WIN_RST = 16'h0000;
    localparam logic [7:0] GPM_IDLE_MAX = 8'hFF;
    // Fixed ability status word: copper gigabit full and half only.
    localparam logic [15:0] GPM_ABILITY_VAL = 16'h3000;
    // Interrupt bit positions and width.
    localparam int GPM_IRQ_MS_FAULT = 0;
    localparam int GPM_IRQ_FAST_ERR = 1;
    localparam int GPM_IRQ_IDLE_ERR = 2;
    localparam int GPM_IRQ_W = 3;

    // Window access functions.
    typedef enum logic [1:0] {
        GPM_FN_ADDR,
        GPM_FN_DATA,
        GPM_FN_DATA_INC_RW,
        GPM_FN_DATA_INC_WR
    } gpm_fn_t;

    // Gigabit control register fields.
    typedef struct packed {
        logic [2:0] test_mode;
        logic manual_en;
        logic manual_master;
        logic multi_port;
        logic adv_full;
        logic adv_half;
    } gpm_gig_ctrl_t;

    // Live status from the physical layer.
    typedef struct packed {
        logic ms_fault;
        logic ms_master;
        logic local_rx_ok;
        logic remote_rx_ok;
        logic lp_full;
        logic lp_half;
        logic idle_err;
        logic descr_locked;
        logic link_up;
        logic lock_err;
        logic link_disc;
        logic rx_err;
        logic tx_err;
        logic ssd_err;
        logic esd_err;
    } gpm_phy_stat_t;

    // Register port request.
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } gpm_req_t;
endpackage

// ==== gpm_regs.sv ====
// Gigabit management register bank with indirect window and interrupts.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
// Notes on behaviour
// - Test mode field, codes 0-4, resets zero.
// - Manual role value used only when enabled.
// - Port type bit, read-write, resets zero.
// - Gigabit full/half advertise bits reset to one.
// - Role fault flag latches high.
// - Resolved role is read-only, one means master.
// - Local and remote receiver status read-only.
// - Partner gigabit full/half abilities read-only.
// - Idle error counter, clears on read.
// - Two-bit access function field, resets zero.
// - Window is address when function zero.
// - Ability status: X zeros, copper gigabit ones.
// - Live descrambler lock and link status.
// - Fast error flags clear after read.
// - Fast status only page zero; page select in every page; others pages 0-2.
// - Index ten is gigabit status, pages 0-2.
module gpm_regs (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port.
    input wire gpm_pkg::gpm_req_t req_in,
    output logic [15:0] rdata_out,
    // Status from the physical layer, on this clock.
    input wire gpm_pkg::gpm_phy_stat_t phy_in,
    // Control towards the physical layer.
    output gpm_pkg::gpm_gig_ctrl_t ctrl_out,
    output logic role_forced_out,
    output logic role_master_out,
    // Indirect window towards the extended devices.
    output logic [4:0] ext_dev_out,
    output logic [15:0] ext_addr_out,
    output logic [15:0] ext_wdata_out,
    output logic ext_wr_out,
    output logic ext_rd_out,
    input wire logic [15:0] ext_rdata_in,
    // Interrupt.
    output logic irq_out
);
    import gpm_pkg::*;

    // Overview of the bank, for whoever picks this block up next.
    // The bank sits between a management host and the physical layer.
    // The host sees sixteen-bit registers selected by a five-bit index.
    // A write is one strobe cycle and lands at the edge that samples it.
    // A read is one strobe cycle and its data stand in the next cycle only.
    // Between reads the read data are held at zero on purpose.
    // This keeps stale values off the bus and makes misses easy to spot.
    // Write and read strobes never come together from the host.
    // Nothing here ever stalls the host, so there is no ready signal.
    //
    // Paging.
    // A small page select register picks which register set is visible.
    // The page register itself answers in every page.
    // The gigabit and window registers answer in the low three pages.
    // The fast link status register answers only in page zero.
    // An index that is not decoded in the current page reads as zero.
    // Writes to such an index are dropped without any side effect.
    // Software that forgets the page therefore sees zeros, not old data.
    //
    // Gigabit control.
    // The upper byte holds test mode, the manual role pair, port type
    // and the two gigabit advertisement bits.
    // The lower byte is reserved; it reads zero and ignores writes.
    // The control fields go out as one packed word to the line logic.
    // The manual role value only reaches role_master_out while enabled; ctrl_out always carries it.
    // With the enable clear, the role output is forced low, so a stale
    // value bit can never leak into role resolution.
    // Reserved test mode codes are stored as written; the line logic
    // is expected to treat them as normal operation.
    //
    // Gigabit status.
    // The role fault bit is latched high and returns to the live state
    // once the status register has been read.
    // Resolved role, receiver states and partner abilities are live.
    // The idle error count saturates instead of wrapping, so a reader
    // never mistakes a storm of errors for a quiet line.
    // Reading the status clears the count; an error in the read cycle
    // starts the new count at one so that no event is lost.
    // The same rule holds for the latched fault: a fault in the read
    // cycle is kept for the next read.
    //
    // Indirect window.
    // The access control register holds a two-bit function and a
    // five-bit device select.
    // With function zero the window holds the extended address.
    // With any other function the window carries data to or from the
    // selected extended device, using the held address.
    // Data accesses raise a one-cycle strobe towards the device.
    // The device answers a read combinationally in the same cycle.
    // Only function two moves the address, and only after a read.
    // Writes never move the address, whatever the function says, so
    // software must rewrite the address for a run of writes.
    //
    // Fixed ability word.
    // Only copper gigabit full and half duplex are reported as able.
    // The fibre ability bits read as zero and nothing can change them.
    //
    // Fast link status.
    // Descrambler lock and link state are live bits.
    // Six error flags latch their events and clear once read.
    // A flag shows its event even in the cycle the event arrives, and an
    // event in the read cycle survives into the following read.
    //
    // Interrupts.
    // Three sticky status bits collect role fault, any fast link error
    // and idle errors; writing a one clears a bit.
    // An event in the same cycle as the clear wins, so it is not lost.
    // The mask has the same layout and resets to all masked.
    // The interrupt output is a level, high while any unmasked bit is
    // set, and it is built only from registers to stay glitch free.
    //
    // Timing.
    // All physical layer inputs are taken to be on this clock already.
    // Event inputs count once per cycle that they are high.
    // The reset is synchronous and active low; every register returns
    // to its documented value at the first edge with reset low.
    //
    // Storage.
    // All state is in flip-flops; one process per concern keeps each
    // piece of state easy to find and to reason about.

    gpm_gig_ctrl_t gig_ctrl;
    gpm_fn_t ext_fn;
    logic [4:0] ext_dev;
    logic [15:0] ext_addr;
    logic [15:0] ext_wdata;
    logic [1:0] page;
    logic ms_fault_lh;
    logic [7:0] idle_cnt;
    logic [5:0] fast_flags;
    logic [GPM_IRQ_W-1:0] irq_stat;
    logic [GPM_IRQ_W-1:0] irq_mask;
    logic [15:0] next_rdata;
    logic [5:0] fast_ev;
    logic wr_ok;
    logic rd_ok;
    logic is_data;

    // True when the index is decoded in the current page.
    function automatic logic hit(input logic [4:0] a, input logic [4:0] idx,
                                 input logic [1:0] pg);
        if (idx == GPM_IDX_FAST_STAT) begin
            hit = (a == idx) && (pg == GPM_PAGE_ZERO);
        end else if (idx == GPM_IDX_PAGE) begin
            hit = (a == idx);
        end else begin
            hit = (a == idx) && (pg <= GPM_PAGE_MAX);
        end
    endfunction

    assign wr_ok = req_in.wr;
    assign rd_ok = req_in.rd;
    assign fast_ev = {phy_in.lock_err, phy_in.link_disc, phy_in.rx_err,
                      phy_in.tx_err, phy_in.ssd_err, phy_in.esd_err};
    assign is_data = (ext_fn != GPM_FN_ADDR);

    // Page select register.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            page <= GPM_PAGE_ZERO;
        end else if (wr_ok && hit(req_in.addr, GPM_IDX_PAGE, page)) begin
            page <= req_in.wdata[1:0];
        end
    end

    // Gigabit control register.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            gig_ctrl.test_mode <= GPM_TEST_RST;
            gig_ctrl.manual_en <= 1'b0;
            gig_ctrl.manual_master <= 1'b0;
            gig_ctrl.multi_port <= 1'b0;
            gig_ctrl.adv_full <= GPM_ADV_FD_RST;
            gig_ctrl.adv_half <= GPM_ADV_HD_RST;
        end else if (wr_ok && hit(req_in.addr, GPM_IDX_GIG_CTRL, page)) begin
            gig_ctrl <= req_in.wdata[15:8];
        end
    end

    // Control outputs; the manual value only counts while enabled.
    always_comb begin
        ctrl_out = gig_ctrl;
        role_forced_out = gig_ctrl.manual_en;
        role_master_out = gig_ctrl.manual_en & gig_ctrl.manual_master;
    end

    // Access control register and the window.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ext_fn <= GPM_FN_ADDR;
            ext_dev <= 5'h00;
        end else if (wr_ok && hit(req_in.addr, GPM_IDX_EXT_CTRL, page)) begin
            ext_fn <= gpm_fn_t'(req_in.wdata[15:14]);
            ext_dev <= req_in.wdata[4:0];
        end
    end

    // Window address; increments after data reads in function two only.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ext_addr <= GPM_WIN_RST;
        end else if (hit(req_in.addr, GPM_IDX_EXT_WIN, page)) begin
            if (wr_ok && !is_data) begin
                ext_addr <= req_in.wdata;
            end else if (rd_ok && ext_fn == GPM_FN_DATA_INC_RW) begin
                ext_addr <= ext_addr + 16'h0001;
            end
        end
    end

    // Write data latch; writes never move the address.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ext_wdata <= GPM_WIN_RST;
        end else if (wr_ok && is_data &&
                     hit(req_in.addr, GPM_IDX_EXT_WIN, page)) begin
            ext_wdata <= req_in.wdata;
        end
    end

    // Strobes towards the extended devices.
    always_comb begin
        ext_dev_out = ext_dev;
        ext_addr_out = ext_addr;
        ext_wdata_out = req_in.wdata;
        ext_wr_out = wr_ok && is_data &&
                     hit(req_in.addr, GPM_IDX_EXT_WIN, page);
        ext_rd_out = rd_ok && is_data &&
                     hit(req_in.addr, GPM_IDX_EXT_WIN, page);
    end

    // Role fault flag holds until status is read; the event wins.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ms_fault_lh <= 1'b0;
        end else if (phy_in.ms_fault) begin
            ms_fault_lh <= 1'b1;
        end else if (rd_ok && hit(req_in.addr, GPM_IDX_GIG_STAT, page)) begin
            ms_fault_lh <= 1'b0;
        end
    end

    // Idle error counter saturates, clears on read, keeps a new error.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            idle_cnt <= 8'h00;
        end else if (rd_ok && hit(req_in.addr, GPM_IDX_GIG_STAT, page)) begin
            idle_cnt <= {7'h00, phy_in.idle_err};
        end else if (phy_in.idle_err && idle_cnt != GPM_IDLE_MAX) begin
            idle_cnt <= idle_cnt + 8'h01;
        end
    end

    // Fast error flags set by events and cleared by a read.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fast_flags <= 6'h00;
        end else if (rd_ok && hit(req_in.addr, GPM_IDX_FAST_STAT, page)) begin
            fast_flags <= fast_ev;
        end else begin
            fast_flags <= fast_flags | fast_ev;
        end
    end

    // Interrupt status: write one to clear, a new event wins.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_stat <= '0;
        end else begin
            for (int i = 0; i < GPM_IRQ_W; i++) begin
                if ((i == GPM_IRQ_MS_FAULT && phy_in.ms_fault) ||
                    (i == GPM_IRQ_FAST_ERR && |fast_ev) ||
                    (i == GPM_IRQ_IDLE_ERR && phy_in.idle_err)) begin
                    irq_stat[i] <= 1'b1;
                end else if (wr_ok && req_in.wdata[i] &&
                             hit(req_in.addr, GPM_IDX_IRQ_STAT, page)) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_mask <= '0;
        end else if (wr_ok && hit(req_in.addr, GPM_IDX_IRQ_MASK, page)) begin
            irq_mask <= req_in.wdata[GPM_IRQ_W-1:0];
        end
    end

    assign irq_out = |(irq_stat & irq_mask);

    // Read multiplexer; reserved bits read zero.
    always_comb begin
        next_rdata = 16'h0000;
        if (hit(req_in.addr, GPM_IDX_GIG_CTRL, page)) begin
            next_rdata = {gig_ctrl, 8'h00};
        end else if (hit(req_in.addr, GPM_IDX_GIG_STAT, page)) begin
            next_rdata = {ms_fault_lh | phy_in.ms_fault,
                          phy_in.ms_master,
                          phy_in.local_rx_ok, phy_in.remote_rx_ok,
                          phy_in.lp_full, phy_in.lp_half,
                          2'h0, idle_cnt};
        end else if (hit(req_in.addr, GPM_IDX_EXT_CTRL, page)) begin
            next_rdata = {ext_fn, 9'h000, ext_dev};
        end else if (hit(req_in.addr, GPM_IDX_EXT_WIN, page)) begin
            next_rdata = is_data ? ext_rdata_in : ext_addr;
        end else if (hit(req_in.addr, GPM_IDX_ABILITY, page)) begin
            next_rdata = GPM_ABILITY_VAL;
        end else if (hit(req_in.addr, GPM_IDX_FAST_STAT, page)) begin
            next_rdata = {phy_in.descr_locked,
                          fast_flags[5] | fast_ev[5],
                          fast_flags[4] | fast_ev[4],
                          phy_in.link_up,
                          fast_flags[3:0] | fast_ev[3:0], 8'h00};
        end else if (hit(req_in.addr, GPM_IDX_IRQ_STAT, page)) begin
            next_rdata = {13'h0000, irq_stat};
        end else if (hit(req_in.addr, GPM_IDX_IRQ_MASK, page)) begin
            next_rdata = {13'h0000, irq_mask};
        end else if (hit(req_in.addr, GPM_IDX_PAGE, page)) begin
            next_rdata = {14'h0000, page};
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_ok) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule

// ==== gpm_regs_assertions.sv ====
// Port-level checks for the gigabit management register bank.
`timescale 1ns/1ns
module gpm_regs_assertions (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port and live status.
    input wire gpm_pkg::gpm_req_t req_in,
    input wire logic [15:0] rdata_out,
    input wire gpm_pkg::gpm_phy_stat_t phy_in,
    // Control and window outputs.
    input wire gpm_pkg::gpm_gig_ctrl_t ctrl_out,
    input wire logic role_forced_out,
    input wire logic role_master_out,
    input wire logic [15:0] ext_addr_out,
    input wire logic [15:0] ext_wdata_out,
    input wire logic ext_wr_out
);
    import gpm_pkg::*;
    logic [1:0] page;
    logic [1:0] fn;
    logic in_pg;
    logic st_rd;
    // Shadows of the page select and window function, as the host set them.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            page <= 2'h0;
            fn <= 2'h0;
        end else if (req_in.wr && req_in.addr == GPM_IDX_PAGE) begin
            page <= req_in.wdata[1:0];
        end else if (req_in.wr && in_pg && req_in.addr == GPM_IDX_EXT_CTRL) begin
            fn <= req_in.wdata[15:14];
        end
    end
    // Decoded accesses shared by several properties.
    assign in_pg = page <= GPM_PAGE_MAX;
    assign st_rd = req_in.rd && in_pg && req_in.addr == GPM_IDX_GIG_STAT;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // A fault seen once, gone, then the status read.
    sequence s_fault_read;
        phy_in.ms_fault ##1 !phy_in.ms_fault ##1 st_rd;
    endsequence
    // Two status reads with no idle error around them.
    sequence s_quiet_reads;
        st_rd && !phy_in.idle_err ##1 !phy_in.idle_err
            ##1 st_rd && !phy_in.idle_err;
    endsequence
    a_ctrl_write: assert property (req_in.wr && in_pg
        && req_in.addr == GPM_IDX_GIG_CTRL && req_in.wdata[15:13] <= 3'h4
        |=> ctrl_out == $past(req_in.wdata[15:8]))
        else $error("control fields differ from written value");
    a_role_apply: assert property (role_forced_out == ctrl_out.manual_en
        && role_master_out == (ctrl_out.manual_en && ctrl_out.manual_master))
        else $error("role outputs differ from control fields");
    a_fault_latch: assert property (s_fault_read |=> rdata_out[15])
        else $error("role fault not held until read");
    a_live_bits: assert property (st_rd |=>
        rdata_out[14:10] == $past(phy_in[13:9]) && rdata_out[9:8] == 2'h0)
        else $error("status live bits wrong");
    a_idle_clear: assert property (s_quiet_reads |=> rdata_out[7:0] == 8'h00)
        else $error("idle count not cleared by read");
    a_win_write: assert property (req_in.wr && in_pg
        && req_in.addr == GPM_IDX_EXT_WIN && fn != 2'h0
        |-> ext_wr_out && ext_wdata_out == req_in.wdata ##1 $stable(ext_addr_out))
        else $error("window data write wrong");
    a_ability_word: assert property (req_in.rd && in_pg
        && req_in.addr == GPM_IDX_ABILITY |=> rdata_out == 16'h3000)
        else $error("ability word wrong");
    a_fast_page: assert property (req_in.rd && page != 2'h0
        && req_in.addr == GPM_IDX_FAST_STAT |=> rdata_out == 16'h0000)
        else $error("fast status seen outside page zero");
endmodule
bind gpm_regs gpm_regs_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_in(req_in), .rdata_out(rdata_out), .phy_in(phy_in),
    .ctrl_out(ctrl_out), .role_forced_out(role_forced_out),
    .role_master_out(role_master_out), .ext_addr_out(ext_addr_out),
    .ext_wdata_out(ext_wdata_out), .ext_wr_out(ext_wr_out));

// ==== gpm_ext_model.sv ====
// Behavioural extended management device behind the indirect window.
`timescale 1ns/1ns
module gpm_ext_model (
    // Clock.
    input wire logic clk_in,
    // Window access from the register bank.
    input wire logic [4:0] dev_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out
);
    logic [15:0] mem [16];
    // Stores window writes; every word starts at zero.
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem[addr_in[3:0]] <= wdata_in;
        end
    end
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h0000;
        end
    end
    // Read data carry the device number; between reads the bus shows junk.
    assign rdata_out = rd_in ? mem[addr_in[3:0]] ^ {11'h000, dev_in}
                             : ~mem[addr_in[3:0]];
endmodule

// ==== gpm_regs_tb.sv ====
// Self-checking bench for the gigabit management register bank.
`timescale 1ns/1ns
module gpm_regs_tb;
    import gpm_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    gpm_req_t req = '0;
    gpm_phy_stat_t phy = '0;
    gpm_gig_ctrl_t ctrl;
    logic [15:0] rdata, eaddr, ewdata, erdata;
    logic [4:0] dev;
    logic forced, master, ewr, erd, irq;
    int fail_count = 0;
    int comparisons = 0;
    // Clock of 100 MHz.
    always #5 clk_in = ~clk_in;
    gpm_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
        .rdata_out(rdata), .phy_in(phy), .ctrl_out(ctrl),
        .role_forced_out(forced), .role_master_out(master),
        .ext_dev_out(dev), .ext_addr_out(eaddr), .ext_wdata_out(ewdata),
        .ext_wr_out(ewr), .ext_rd_out(erd), .ext_rdata_in(erdata),
        .irq_out(irq));
    gpm_ext_model ext (.clk_in(clk_in), .dev_in(dev), .addr_in(eaddr),
        .wdata_in(ewdata), .wr_in(ewr), .rd_in(erd), .rdata_out(erdata));
    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Compares a seen value against the expected one.
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One write strobe cycle.
    task automatic wr(logic [4:0] a, logic [15:0] d);
        @(posedge clk_in);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask
    // One read strobe cycle; the answer is checked in the next cycle.
    task automatic rd(logic [4:0] a, logic [15:0] e);
        @(posedge clk_in);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata, e);
    endtask
    // Raises the status bits in m for n cycles.
    task automatic pulse(logic [14:0] m, int n);
        @(posedge clk_in);
        phy <= gpm_phy_stat_t'(phy | m);
        repeat (n) @(posedge clk_in);
        phy <= gpm_phy_stat_t'(phy & ~m);
    endtask
    // Guards against a hung run.
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(GPM_IDX_GIG_CTRL, 16'h0300);
        rd(GPM_IDX_EXT_CTRL, 16'h0000);
        rd(GPM_IDX_EXT_WIN, 16'h0000);
        rd(GPM_IDX_ABILITY, 16'h3000);
        rd(5'h03, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            wr(GPM_IDX_GIG_CTRL, {i[2:0], 13'h1AFF});
            rd(GPM_IDX_GIG_CTRL, {i[2:0], 13'h1A00});
            chk("ctrl", {8'h00, ctrl}, {8'h00, i[2:0], 5'h1A});
            chk("role", {14'h0, forced, master}, 16'h0003);
        end
        wr(GPM_IDX_GIG_CTRL, 16'h0C00);
        rd(GPM_IDX_GIG_CTRL, 16'h0C00);
        chk("role", {14'h0, forced, master}, 16'h0000);
        @(posedge clk_in) phy <= gpm_phy_stat_t'(15'h34C0);
        pulse(15'h0100, 3);
        pulse(15'h4000, 1);
        rd(GPM_IDX_GIG_STAT, 16'hE803);
        rd(GPM_IDX_GIG_STAT, 16'h6800);
        pulse(15'h0009, 1);
        rd(GPM_IDX_FAST_STAT, 16'h9900);
        pulse(15'h0036, 1);
        rd(GPM_IDX_FAST_STAT, 16'hF600);
        rd(GPM_IDX_FAST_STAT, 16'h9000);
        wr(GPM_IDX_PAGE, 16'h0002);
        rd(GPM_IDX_FAST_STAT, 16'h0000);
        rd(GPM_IDX_GIG_STAT, 16'h6800);
        wr(GPM_IDX_PAGE, 16'h0003);
        rd(GPM_IDX_GIG_CTRL, 16'h0000);
        wr(GPM_IDX_PAGE, 16'h0000);
        wr(GPM_IDX_EXT_CTRL, 16'h3FE5);
        rd(GPM_IDX_EXT_CTRL, 16'h0005);
        wr(GPM_IDX_EXT_WIN, 16'h0002);
        rd(GPM_IDX_EXT_WIN, 16'h0002);
        wr(GPM_IDX_EXT_CTRL, 16'h4005);
        wr(GPM_IDX_EXT_WIN, 16'hABCD);
        rd(GPM_IDX_EXT_WIN, 16'hABC8);
        rd(GPM_IDX_EXT_WIN, 16'hABC8);
        wr(GPM_IDX_EXT_CTRL, 16'h8005);
        wr(GPM_IDX_EXT_WIN, 16'h1111);
        rd(GPM_IDX_EXT_WIN, 16'h1114);
        rd(GPM_IDX_EXT_WIN, 16'h0005);
        wr(GPM_IDX_EXT_CTRL, 16'hC005);
        wr(GPM_IDX_EXT_WIN, 16'h2222);
        rd(GPM_IDX_EXT_WIN, 16'h2227);
        wr(GPM_IDX_EXT_CTRL, 16'h0005);
        rd(GPM_IDX_EXT_WIN, 16'h0004);
        rd(GPM_IDX_IRQ_STAT, 16'h0007);
        chk("irq", {15'h0, irq}, 16'h0000);
        wr(GPM_IDX_IRQ_MASK, 16'h0002);
        #1 chk("irq", {15'h0, irq}, 16'h0001);
        wr(GPM_IDX_IRQ_STAT, 16'h0002);
        #1 chk("irq", {15'h0, irq}, 16'h0000);
        rd(GPM_IDX_IRQ_STAT, 16'h0005);
        report_and_stop();
    end
endmodule
